// ---- irq_gate_map.svh ----
/*
 Offsets, field positions, reset values and masks for the
 interrupt enable gating block. Assumes a 32-bit APB with word registers.
*/
`ifndef IRQ_GATE_MAP_SVH
`define IRQ_GATE_MAP_SVH

`define OFF_ENABLE_FIRST   12'h000
`define OFF_ENABLE_SECOND  12'h004
`define OFF_EDGE_SELECT    12'h008
`define OFF_FLAGS_FIRST    12'h00c
`define OFF_FLAGS_SECOND   12'h010
`define OFF_PIN_MODE       12'h014
`define OFF_EVT_STATUS     12'h018
`define OFF_EVT_MASK       12'h01c

`define RST_ENABLE         8'h00
`define RST_EDGE_SELECT    8'he0
`define RST_FLAGS_FIRST    8'h20
`define RST_FLAGS_SECOND   8'h00
`define RST_PIN_MODE       5'h00
`define RST_EVT            2'h0

`define BIT_FIRST_RESERVED 5
`define EDGE_RESERVED_MASK 8'he0

`endif

// ---- irq_gate_pkg.sv ----
/*
 Types for the interrupt enable gating block.
 Assumes irq_gate_map.svh supplies the numbers.
*/
package irq_gate_pkg;

    typedef struct packed {
        logic       paddr_ok;
        logic [7:0] data;
    } reg_rd_t;

    // Per-source peripheral request pulses, one cycle each
    typedef struct packed {
        logic       timer_a_ovf;
        logic       serial1_done;
        logic [7:0] wakeup;
        logic       direct_xfer;
        logic       adc_done;
        logic       serial2_done;
        logic       serial2_abort;
        logic       timer_g_capture;
        logic       timer_g_ovf;
        logic       timer_fh_match;
        logic       timer_fh_ovf;
        logic       timer_fl_match;
        logic       timer_fl_ovf;
        logic       timer_c_ovf;
        logic       timer_c_unf;
        logic       timer_b_ovf;
    } src_evt_t;

endpackage

// ---- interrupt_enable_gating.sv ----
/*
 Interrupt enable gating: two enable registers, edge detection on the five
 external pins, request flags cleared by writing 0, gated requests to the core.
 Assumes an APB master on sys_clk, peripheral pulses on sys_clk, and
 external pins arriving asynchronously.
*/
// Functional notes
// - Pin 0 edge select: 0 falling, 1 rising
// - First enable register 8 bits, resets zero
// - First bit 7 gates timer A overflow
// - First bit 6 gates serial one done
// - First bit 5 gates all eight wakeups
// - First bits 4..0 gate external pins
// - Second enable register 8 bits, resets zero
// - Second bit 7 gates direct transfer
// - Second bit 6 gates converter requests
// - Second bit 5 gates serial two both
// - Second bit 4 gates timer G both
// - Second bit 3 gates timer F high
// - Second bit 2 gates timer F low
// - Second bit 1 gates timer C
// - Second bit 0 gates timer B
// - Flags stick; write 0 clears, 1 ignored
// - Pin flag sets on chosen edge, interrupt mode
`include "irq_gate_map.svh"
`timescale 1ns/1ns
`default_nettype none

module interrupt_enable_gating
(
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic [4:0]             ext_pin,
    input  wire logic [7:0]             wakeup_pin,
    input  wire irq_gate_pkg::src_evt_t src_evt,
    output var  logic [7:0]             core_req_first,
    output var  logic [7:0]             core_req_second,
    output var  logic                   wakeup_flag_hold,
    output var  logic                   irq
);

    logic [7:0] interrupt_enable_first;
    logic [7:0] interrupt_enable_second;
    logic [7:0] edge_select;
    logic [7:0] flags_first;
    logic [7:0] flags_second;
    logic [7:0] wakeup_flags;
    logic [4:0] pin_mode;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    logic [4:0] pin_prev;
    logic [7:0] wk_meta;
    logic [7:0] wk_sync;
    logic [7:0] wk_prev;

    function automatic logic [7:0] clear_by_zero(input logic [7:0] cur,
                                                 input logic [7:0] set_v,
                                                 input logic       wr,
                                                 input logic [7:0] wd);
        // Set wins over a simultaneous clear
        clear_by_zero = (wr ? (cur & wd) : cur) | set_v;
    endfunction

    // APB decode
    wire        access     = psel & penable;
    // Write lands only at the edge where the master sees pready high
    wire        wr         = access & pwrite & pready;
    wire        hit_en1    = paddr == `OFF_ENABLE_FIRST;
    wire        hit_en2    = paddr == `OFF_ENABLE_SECOND;
    wire        hit_edge   = paddr == `OFF_EDGE_SELECT;
    wire        hit_fl1    = paddr == `OFF_FLAGS_FIRST;
    wire        hit_fl2    = paddr == `OFF_FLAGS_SECOND;
    wire        hit_mode   = paddr == `OFF_PIN_MODE;
    wire        hit_status = paddr == `OFF_EVT_STATUS;
    wire        hit_mask   = paddr == `OFF_EVT_MASK;
    wire        mapped     = hit_en1 | hit_en2 | hit_edge | hit_fl1 | hit_fl2
                           | hit_mode | hit_status | hit_mask;

    // Edge detection on synchronised pins
    wire [4:0] rise_pin = pin_sync & ~pin_prev;
    wire [4:0] fall_pin = ~pin_sync & pin_prev;
    // Pin 0 uses edge select bit 0; others alike
    wire [4:0] pin_edge = (edge_select[4:0] & rise_pin)
                        | (~edge_select[4:0] & fall_pin);
    wire [4:0] pin_set  = pin_edge & pin_mode;
    // Wakeup pins are active low, falling edge
    wire [7:0] wk_set   = ~wk_sync & wk_prev;

    wire [7:0] set_first = {src_evt.timer_a_ovf, src_evt.serial1_done, 1'b0, pin_set};
    wire [7:0] set_second = {src_evt.direct_xfer,
                             src_evt.adc_done,
                             src_evt.serial2_done | src_evt.serial2_abort,
                             src_evt.timer_g_capture | src_evt.timer_g_ovf,
                             src_evt.timer_fh_match | src_evt.timer_fh_ovf,
                             src_evt.timer_fl_match | src_evt.timer_fl_ovf,
                             src_evt.timer_c_ovf | src_evt.timer_c_unf,
                             src_evt.timer_b_ovf};

    // Reserved bit of first flags reads as 1; wakeup folded into it for gating
    wire [7:0] flags_first_view = flags_first | (8'h01 << `BIT_FIRST_RESERVED);
    wire       wakeup_pending   = |wakeup_flags;

    wire [7:0] gate_first = {flags_first[7:6], wakeup_pending, flags_first[4:0]}
                          & interrupt_enable_first;
    wire [7:0] gate_second = flags_second & interrupt_enable_second;

    // Block events: set every cycle a gated request is pending, one bit per register
    wire [1:0] evt_set  = {|gate_second, |gate_first};

    wire [7:0] rd_mux =
        hit_en1    ? interrupt_enable_first :
        hit_en2    ? interrupt_enable_second :
        hit_edge   ? edge_select :
        hit_fl1    ? flags_first_view :
        hit_fl2    ? flags_second :
        hit_mode   ? {3'h0, pin_mode} :
        hit_status ? {6'h00, evt_status} :
        hit_mask   ? {6'h00, evt_mask} : 8'h00;

    wire [7:0] next_flags_first  = clear_by_zero(flags_first, set_first,
                                                 wr & hit_fl1, pwdata[7:0])
                                 & ~(8'h01 << `BIT_FIRST_RESERVED);
    wire [7:0] next_flags_second = clear_by_zero(flags_second, set_second,
                                                 wr & hit_fl2, pwdata[7:0]);
    // Wakeup flags cleared together with first flags bit 5 written 0
    wire [7:0] next_wakeup_flags = (wr & hit_fl1 & ~pwdata[`BIT_FIRST_RESERVED])
                                 ? wk_set : (wakeup_flags | wk_set);
    wire [1:0] next_evt_status   = (evt_status
                                 & ~((wr & hit_status) ? pwdata[1:0] : 2'h0))
                                 | evt_set;

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        pin_meta <= ext_pin;
        pin_sync <= pin_meta;
        wk_meta  <= wakeup_pin;
        wk_sync  <= wk_meta;
        if (srst)
        begin
            pin_prev <= 5'h1f;
            wk_prev  <= 8'hff;
        end
        else
        begin
            pin_prev <= pin_sync;
            wk_prev  <= wk_sync;
        end
    end

    // Software-written registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            interrupt_enable_first  <= `RST_ENABLE;
            interrupt_enable_second <= `RST_ENABLE;
            edge_select             <= `RST_EDGE_SELECT;
            pin_mode                <= `RST_PIN_MODE;
            evt_mask                <= `RST_EVT;
        end
        else if (wr)
        begin
            if (hit_en1)
                interrupt_enable_first <= pwdata[7:0];
            if (hit_en2)
                interrupt_enable_second <= pwdata[7:0];
            if (hit_edge)
                edge_select <= pwdata[7:0] | `EDGE_RESERVED_MASK;
            if (hit_mode)
                pin_mode <= pwdata[4:0];
            if (hit_mask)
                evt_mask <= pwdata[1:0];
        end
    end

    // Hardware-set flags
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            flags_first  <= `RST_FLAGS_FIRST & ~(8'h01 << `BIT_FIRST_RESERVED);
            flags_second <= `RST_FLAGS_SECOND;
            wakeup_flags <= 8'h00;
            evt_status   <= `RST_EVT;
        end
        else
        begin
            flags_first  <= next_flags_first;
            flags_second <= next_flags_second;
            wakeup_flags <= next_wakeup_flags;
            evt_status   <= next_evt_status;
        end
    end

    // Registered outputs; bus answers in the access cycle's next edge
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            prdata           <= 32'h0000_0000;
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            core_req_first   <= 8'h00;
            core_req_second  <= 8'h00;
            wakeup_flag_hold <= 1'b0;
            irq              <= 1'b0;
        end
        else
        begin
            pready           <= access & ~pready;
            pslverr          <= access & ~pready & ~mapped;
            prdata           <= (access & ~pready & ~pwrite) ? {24'h000000, rd_mux}
                                                             : 32'h0000_0000;
            core_req_first   <= gate_first;
            core_req_second  <= gate_second;
            wakeup_flag_hold <= wakeup_pending;
            irq              <= |(next_evt_status & evt_mask);
        end
    end

endmodule

`default_nettype wire

// ---- irq_gate_checker_assertions.sv ----
/* Port checker for interrupt_enable_gating.
   Assumes sys_clk with synchronous srst; bound after the module. */
`timescale 1ns/1ns
`default_nettype none
module irq_gate_checker
(
    input wire logic                   sys_clk,
    input wire logic                   srst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire irq_gate_pkg::src_evt_t src_evt,
    input wire logic [7:0]             core_req_first,
    input wire logic [7:0]             core_req_second,
    input wire logic                   wakeup_flag_hold,
    input wire logic                   irq
);
    wire logic wr_acc = psel && penable && pwrite;
    wire logic evt_any = |src_evt;
    wire logic req_any = |{core_req_first, core_req_second};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    rdy_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_with_rdy_a: assert property (pslverr |-> pready) else $error("stray pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
    // Mid-run reset must also clear outputs, so no disable here
    rst_clear_a: assert property (disable iff (1'b0) srst |=> !irq && !req_any)
        else $error("outputs after reset");
    tb_rise_a: assert property ($rose(core_req_second[0])
        |-> $past(src_evt.timer_b_ovf, 2) || $past(wr_acc, 2)) else $error("timer b rise");
    req_keep_a: assert property ($changed(core_req_second)
        |-> $past(wr_acc, 2) || $past(evt_any, 2) || $past(srst)) else $error("req moved");
    req_fall_a: assert property ($fell(req_any)
        |-> $past(wr_acc, 2) || $past(srst)) else $error("req fell alone");
    wake_gate_a: assert property (core_req_first[5] |-> wakeup_flag_hold)
        else $error("wakeup req without flag");
    irq_cause_a: assert property ($rose(irq)
        |-> req_any || $past(req_any) || $past(wr_acc, 2)) else $error("irq without cause");
    cover property (core_req_second[0]);
    cover property (irq);
    cover property (pslverr);
    cover property (wakeup_flag_hold);
endmodule
bind interrupt_enable_gating irq_gate_checker irq_gate_checker_inst (.sys_clk, .srst, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .src_evt, .core_req_first,
    .core_req_second, .wakeup_flag_hold, .irq);
`default_nettype wire

// ---- periph_evt_model.sv ----
/* Peripheral side model: one-cycle event pulse on a chosen src_evt bit.
   Assumes the bench triggers it on sys_clk. */
`timescale 1ns/1ns
`default_nettype none
module periph_evt_model
(
    input  wire logic                   sys_clk,
    input  wire logic                   fire,
    input  wire logic [4:0]             sel,
    output var  irq_gate_pkg::src_evt_t src_evt
);
    initial src_evt = '0;
    // Peripherals emit single-cycle pulses; flags must hold them
    always @(posedge sys_clk)
        src_evt <= fire ? irq_gate_pkg::src_evt_t'(23'h1 << sel) : '0;
endmodule
`default_nettype wire

// ---- tb_interrupt_enable_gating.sv ----
/* Self-checking bench for interrupt_enable_gating over APB.
   Assumes periph_evt_model drives src_evt; checker is bound. */
`timescale 1ns/1ns
`default_nettype none
module tb_interrupt_enable_gating;
    logic                   sys_clk, srst, psel, penable, pwrite, pready, pslverr, irq;
    logic                   fire, sel_first, wakeup_flag_hold;
    logic [4:0]             sel, ext_pin;
    logic [7:0]             wakeup_pin, core_req_first, core_req_second;
    logic [11:0]            paddr;
    logic [31:0]            pwdata, prdata, rd;
    irq_gate_pkg::src_evt_t src_evt;
    int                     num_errors = 0, total_checks = 0;
    wire logic [7:0]        req = sel_first ? core_req_first : core_req_second;

    interrupt_enable_gating interrupt_enable_gating_inst (.sys_clk, .srst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_pin, .wakeup_pin,
        .src_evt, .core_req_first, .core_req_second, .wakeup_flag_hold, .irq);
    periph_evt_model periph_evt_model_inst (.sys_clk, .fire, .sel, .src_evt);

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        chk({31'h0, pslverr}, {31'h0, a > 12'h01c});
        psel <= 1'b0;
        penable <= 1'b0;
        // Written value reaches the registered outputs one edge later
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, e);
    endtask

    task automatic pulse(input logic [4:0] s);
        fire <= 1'b1;
        sel <= s;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        logic [7:0]  m, fx;
        logic [11:0] ea;
        srst = 1'b1;
        {psel, penable, pwrite, fire, sel_first, paddr, pwdata, sel} = '0;
        ext_pin = 5'h1f;
        wakeup_pin = 8'hff;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rc(12'h000, 32'h0);
        rc(12'h004, 32'h0);
        rc(12'h008, 32'he0);
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, k[1] ? 12'h004 : 12'h000, k[0] ? 8'ha5 : 8'h5a);
            rc(k[1] ? 12'h004 : 12'h000, k[0] ? 32'ha5 : 32'h5a);
        end
        rc(12'h020, 32'h0);
        apb(1'b1, 12'h000, 8'h00);
        apb(1'b1, 12'h004, 8'h00);
        // Sources 0..12 map to the second register; 21, 22 to the first
        for (int i = 0; i < 15; i++)
        begin
            sel_first = i > 12;
            m = 8'h1 << (i == 0 ? 0 : i > 12 ? i - 7 : i > 10 ? i - 5 : (i + 1) / 2);
            ea = sel_first ? 12'h000 : 12'h004;
            fx = sel_first ? 8'h20 : 8'h00;
            pulse(sel_first ? 5'(i + 8) : 5'(i));
            chk({24'h0, req}, 32'h0);
            rc(ea + 12'h00c, {24'h0, m | fx});
            apb(1'b1, ea, m);
            chk({24'h0, req}, {24'h0, m});
            apb(1'b1, ea, 8'h00);
            apb(1'b1, ea + 12'h00c, 8'hff);
            rc(ea + 12'h00c, {24'h0, m | fx});
            apb(1'b1, ea + 12'h00c, ~m);
            rc(ea + 12'h00c, {24'h0, fx});
        end
        sel_first = 1'b1;
        apb(1'b1, 12'h014, 8'h01);
        apb(1'b1, 12'h000, 8'h03);
        ext_pin <= 5'h1c;
        repeat (8) @(posedge sys_clk);
        rc(12'h00c, 32'h21);
        chk({24'h0, req}, 32'h1);
        apb(1'b1, 12'h00c, 8'hfe);
        apb(1'b1, 12'h008, 8'h01);
        ext_pin <= 5'h1f;
        repeat (8) @(posedge sys_clk);
        rc(12'h00c, 32'h21);
        apb(1'b1, 12'h00c, 8'h00);
        wakeup_pin <= 8'hf7;
        repeat (8) @(posedge sys_clk);
        chk({24'h0, req}, 32'h0);
        apb(1'b1, 12'h000, 8'h20);
        chk({23'h0, wakeup_flag_hold, req}, 32'h120);
        apb(1'b1, 12'h00c, 8'hdf);
        chk({31'h0, wakeup_flag_hold}, 32'h0);
        apb(1'b1, 12'h004, 8'h01);
        apb(1'b1, 12'h01c, 8'h02);
        pulse(5'd0);
        chk({31'h0, irq}, 32'h1);
        rc(12'h018, 32'h3);
        apb(1'b1, 12'h01c, 8'h00);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h010, 8'h00);
        apb(1'b1, 12'h018, 8'h03);
        rc(12'h018, 32'h0);
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
